//--- hdl/aesd_pkg.sv
// Shared types and constants for the axis enable and shutdown supervisor.
// Assumes one clock, the cyclic exchange tick, and a plain register port.
package aesd_pkg;

    // ------------------------------------------------------------------
    // Sizes and fixed codes
    // ------------------------------------------------------------------
    localparam int          AESD_AXES         = 4;
    localparam logic [15:0] AESD_ALARM_ENLOST = 16'h546c;  // Alarm 21612

    // ------------------------------------------------------------------
    // Register map (byte addresses) and values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0]  AESD_REG_BRAKE    = 8'h00;  // fault_braking_ramp_time
    localparam logic [7:0]  AESD_REG_DELAY    = 8'h04;  // drive_shutdown_delay_time
    localparam logic [7:0]  AESD_REG_STILL    = 8'h08;  // standstill_speed_tolerance
    localparam logic [7:0]  AESD_REG_LUBE     = 8'h0c;  // lube_travel_distance
    localparam logic [7:0]  AESD_REG_RAMPTOL  = 8'h10;  // Ramp-up tolerance band
    localparam logic [7:0]  AESD_REG_STATUS   = 8'h14;  // Read-only state
    localparam logic [15:0] AESD_RST_BRAKE    = 16'h0064;
    localparam logic [23:0] AESD_RST_DELAY    = 24'h0003e8;
    localparam logic [15:0] AESD_RST_STILL    = 16'h0004;
    localparam logic [15:0] AESD_RST_LUBE     = 16'h1000;
    localparam logic [15:0] AESD_RST_RAMPTOL  = 16'h0008;

    // Status register field positions
    localparam int AESD_ST_MODE_LSB  = 0;   // Two bits per axis
    localparam int AESD_ST_ALARM_BIT = 16;
    localparam int AESD_ST_ABORT_BIT = 17;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {AX_IDLE, AX_RUN, AX_BRAKE, AX_LOCK} aesd_mode_e;

    // Request bits from the controller program and drive feedback per axis
    typedef struct packed {
        logic        enableReq;
        logic        intInhibitReq;
        logic        pulseEnReq;
        logic        groupMember;
        logic        driveAvail;
        logic        driveOk;
        logic        driveRamped;
        logic [15:0] actSpeed;     // Signed, per tick
        logic [15:0] setSpeed;     // Signed
        logic [15:0] travel;       // Unsigned distance this tick
    } aesd_axin_s;

    // Status bits back to the controller program per axis
    typedef struct packed {
        logic        posCtrlActive;
        logic        spdCtrlActive;
        logic        curCtrlActive;
        logic        stationary;
        logic        lubePulse;
        logic        driveReady;
        logic        integratorOff;
        logic        pulsesEnabled;
        logic        rampUpDone;
        logic        brakeActive;
        logic        zeroSetpoint;
        logic [31:0] actualPos;
    } aesd_axout_s;

    // Private per-axis state
    typedef struct packed {
        aesd_mode_e  mode;
        logic [23:0] timer;
        logic        wasMoving;
        logic [15:0] lubeAcc;
        logic [15:0] prevSet;
        aesd_axout_s out;
    } aesd_axst_s;

endpackage : aesd_pkg

//--- hdl/aesd_core.sv
// Axis and spindle enable supervision with cyclic status flags.
// Assumes mclk is the cyclic exchange tick and all inputs are synchronous to it.
//
// Behaviour
// - Emergency stop withdraws the enable of every axis and spindle.
// - Moving axis losing enable is rapid-stopped, then the enable-loss alarm is raised.
// - Enable loss opens the position loop and starts the shutdown delay.
// - Drive enable drops at zero speed or at the latest on delay expiry.
// - Delay expiry while moving still drops the drive, with zero setpoint.
// - Position keeps being acquired; an axis stopped from motion stays disabled until control reset.
// - Enable loss on one traversing group axis rapid-stops every traversing group axis.
// - After a group stop the interrupted program may not continue.
// - Integrator inhibit request turns the speed loop proportional-only.
// - Pulses only when requested and all other enables are present.
// - Drives-cyclic bit when all available drives reached ramp-up.
// - Group drive-ready bit only while all available drives are ready.
// - Kernel alarm bit while any kernel alarm is pending.
// - Temperature or fan monitor trip sets its own status bit.
// - Channel alarm bit while any channel alarm is pending.
// - Processing-stop bit while an alarm has stopped the program.
// - Foreign-language bit after the language switch command executed.
// - Stationary bit while speed lies within standstill tolerance.
// - Three bits report position, speed and current loop closed.
// - Lubrication bit toggles after each lubrication distance travelled.
// - Feedback bits: drive ready, integrator disabled, pulses enabled.
// - Ramp-up done once speed meets setpoint; load dips do not clear it.
// - Enable request closes the position loop of an idle axis and keeps it closed until enable loss or a group stop.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module aesd_core
    import aesd_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic                         ctrlReset,
    input  wire logic                         estopActive,
    input  wire logic                         tempFault,
    input  wire logic                         kernelAlarmIn,
    input  wire logic                         chanAlarmIn,
    input  wire logic                         chanStopAlarmIn,
    input  wire logic                         foreignLangDone,
    input  wire logic                         nativeLangDone,
    input  wire aesd_axin_s [AESD_AXES-1:0]   axIn,
    output var aesd_axout_s [AESD_AXES-1:0]   axOut,
    output logic [15:0]                       brakeRampTime,
    output logic                              drivesCyclic,
    output logic                              groupDriveReady,
    output logic                              kernelAlarm,
    output logic                              tempAlarm,
    output logic                              chanAlarm,
    output logic                              chanStopAlarm,
    output logic                              foreignLang,
    output logic                              programAbort,
    output logic [15:0]                       alarmCode,
    input  wire logic [7:0]                   regAddr,
    input  wire logic [31:0]                  regWdata,
    input  wire logic                         regWr,
    input  wire logic                         regRd,
    output logic [31:0]                       regRdata
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        aesd_axst_s [AESD_AXES-1:0] ax;
        logic [15:0] brake;
        logic [23:0] delay;
        logic [15:0] still;
        logic [15:0] lube;
        logic [15:0] rampTol;
        logic [31:0] rdata;
        logic        enAlarm;
        logic        abort;
        logic        foreign;
        logic        cyclic;
        logic        grpReady;
        logic        kAlarm;
        logic        tAlarm;
        logic        cAlarm;
        logic        cStop;
    } aesd_state_s;

    aesd_state_s st_q;
    aesd_state_s st_d;

    // Magnitude of a signed 16-bit value; 0x8000 stays 0x8000 unsigned
    function automatic logic [15:0] aesd_mag(input logic [15:0] v);
        aesd_mag = v[15] ? 16'((~v) + 16'h0001) : v;
    endfunction : aesd_mag

    // ------------------------------------------------------------------
    // Group trip detection, ahead of the per-axis update
    // ------------------------------------------------------------------
    logic [AESD_AXES-1:0] moving;
    logic [AESD_AXES-1:0] enLost;
    logic [AESD_AXES-1:0] tripSrc;
    logic                 groupTrip;
    logic                 allReady;
    logic                 allRamped;

    // One generate loop derives the per-axis conditions
    for (genvar i = 0; i < AESD_AXES; i++) begin : g_cond
        assign moving[i]  = aesd_mag(axIn[i].actSpeed) > st_q.still;
        assign enLost[i]  = estopActive | ~axIn[i].enableReq;
        assign tripSrc[i] = axIn[i].groupMember & enLost[i] & moving[i]
                          & (st_q.ax[i].mode == AX_RUN);
    end

    assign groupTrip = |tripSrc;

    // Unavailable drives are left out of both group flags
    always_comb begin
        allReady  = 1'b1;
        allRamped = 1'b1;
        for (int i = 0; i < AESD_AXES; i++) begin
            if (axIn[i].driveAvail && !axIn[i].driveOk) begin
                allReady = 1'b0;
            end
            if (axIn[i].driveAvail && !axIn[i].driveRamped) begin
                allRamped = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic, sampled once per exchange tick
    // ------------------------------------------------------------------
    always_comb begin
        logic [16:0] lubeSum;
        logic [16:0] rampErr;
        logic        spdOn;
        logic        alarmNow;
        lubeSum  = 17'h00000;
        rampErr  = 17'h00000;
        spdOn    = 1'b0;
        alarmNow = 1'b0;
        st_d     = st_q;
        st_d.rdata = 32'h00000000;

        // Register writes steer the shutdown and status timing
        if (regWr) begin
            case (regAddr)
                AESD_REG_BRAKE:   st_d.brake   = regWdata[15:0];
                AESD_REG_DELAY:   st_d.delay   = regWdata[23:0];
                AESD_REG_STILL:   st_d.still   = regWdata[15:0];
                AESD_REG_LUBE:    st_d.lube    = regWdata[15:0];
                AESD_REG_RAMPTOL: st_d.rampTol = regWdata[15:0];
                default:          ;
            endcase
        end

        for (int i = 0; i < AESD_AXES; i++) begin
            // Supervision sequence per axis
            case (st_q.ax[i].mode)
                AX_IDLE: begin
                    if (!enLost[i]) begin
                        st_d.ax[i].mode = AX_RUN;
                    end
                end
                AX_RUN: begin
                    // Group stop also hits axes whose own enable is still present
                    if (enLost[i] || (groupTrip && axIn[i].groupMember && moving[i])) begin
                        st_d.ax[i].mode      = AX_BRAKE;
                        st_d.ax[i].timer     = st_q.delay;
                        st_d.ax[i].wasMoving = moving[i];
                    end
                end
                AX_BRAKE: begin
                    if (!moving[i]) begin
                        // Zero speed reached: drive may drop now
                        st_d.ax[i].mode = st_q.ax[i].wasMoving ? AX_LOCK : AX_IDLE;
                        alarmNow        = alarmNow | st_q.ax[i].wasMoving;
                    end else if (st_q.ax[i].timer == 24'h000000) begin
                        // Delay set too short: abrupt stop on a zero setpoint
                        st_d.ax[i].mode             = AX_LOCK;
                        st_d.ax[i].out.zeroSetpoint = 1'b1;
                        alarmNow                    = 1'b1;
                    end else begin
                        st_d.ax[i].timer = 24'(st_q.ax[i].timer - 24'h000001);
                    end
                end
                AX_LOCK: begin
                    if (ctrlReset) begin
                        st_d.ax[i].mode             = AX_IDLE;
                        st_d.ax[i].out.zeroSetpoint = 1'b0;
                    end
                end
                default: st_d.ax[i].mode = AX_IDLE;
            endcase

            // Loop and drive feedback follow the new mode
            spdOn = (st_d.ax[i].mode == AX_RUN) || (st_d.ax[i].mode == AX_BRAKE);
            st_d.ax[i].out.posCtrlActive = (st_d.ax[i].mode == AX_RUN);
            st_d.ax[i].out.spdCtrlActive = spdOn;
            st_d.ax[i].out.brakeActive   = (st_d.ax[i].mode == AX_BRAKE);
            st_d.ax[i].out.pulsesEnabled = axIn[i].pulseEnReq & axIn[i].driveAvail
                                         & axIn[i].driveOk & spdOn;
            st_d.ax[i].out.curCtrlActive = st_d.ax[i].out.pulsesEnabled;
            st_d.ax[i].out.driveReady    = axIn[i].driveOk
                                         & (st_d.ax[i].mode != AX_LOCK);
            st_d.ax[i].out.integratorOff = axIn[i].intInhibitReq;
            st_d.ax[i].out.stationary    = ~moving[i];

            // Position is tracked in every mode, locked or not
            st_d.ax[i].out.actualPos = 32'(st_q.ax[i].out.actualPos
                                     + {{16{axIn[i].actSpeed[15]}}, axIn[i].actSpeed});

            // Lubrication toggle, the excess distance is dropped
            lubeSum = {1'b0, st_q.ax[i].lubeAcc} + {1'b0, axIn[i].travel};
            if (lubeSum > {1'b0, st_q.lube}) begin
                st_d.ax[i].out.lubePulse = ~st_q.ax[i].out.lubePulse;
                st_d.ax[i].lubeAcc       = 16'h0000;
            end else begin
                st_d.ax[i].lubeAcc = lubeSum[15:0];
            end

            // Ramp-up done: cleared only by a new setpoint, never by load dips
            st_d.ax[i].prevSet = axIn[i].setSpeed;
            rampErr = 17'({axIn[i].actSpeed[15], axIn[i].actSpeed}
                        - {axIn[i].setSpeed[15], axIn[i].setSpeed});
            if (axIn[i].setSpeed != st_q.ax[i].prevSet) begin
                st_d.ax[i].out.rampUpDone = 1'b0;
            end else if ((rampErr[16] ? 17'((~rampErr) + 17'h00001) : rampErr)
                         <= {1'b0, st_q.rampTol}) begin
                st_d.ax[i].out.rampUpDone = 1'b1;
            end
        end

        // Sticky flags: a new event wins over a reset in the same tick
        if (ctrlReset) begin
            st_d.enAlarm = 1'b0;
            st_d.abort   = 1'b0;
            st_d.foreign = 1'b0;
        end
        if (alarmNow) begin
            st_d.enAlarm = 1'b1;
        end
        if (groupTrip) begin
            st_d.abort = 1'b1;
        end
        if (nativeLangDone) begin
            st_d.foreign = 1'b0;
        end
        if (foreignLangDone) begin
            st_d.foreign = 1'b1;
        end

        // General and channel status bits, refreshed every tick
        st_d.cyclic   = allRamped;
        st_d.grpReady = allReady;
        st_d.kAlarm   = st_d.enAlarm | kernelAlarmIn;
        st_d.tAlarm   = tempFault;
        st_d.cAlarm   = st_d.enAlarm | chanAlarmIn;
        st_d.cStop    = st_d.abort | chanStopAlarmIn;

        // Read data, valid only in the cycle after the strobe
        if (regRd) begin
            case (regAddr)
                AESD_REG_BRAKE:   st_d.rdata = {16'h0000, st_q.brake};
                AESD_REG_DELAY:   st_d.rdata = {8'h00, st_q.delay};
                AESD_REG_STILL:   st_d.rdata = {16'h0000, st_q.still};
                AESD_REG_LUBE:    st_d.rdata = {16'h0000, st_q.lube};
                AESD_REG_RAMPTOL: st_d.rdata = {16'h0000, st_q.rampTol};
                AESD_REG_STATUS: begin
                    for (int i = 0; i < AESD_AXES; i++) begin
                        st_d.rdata[AESD_ST_MODE_LSB + 2*i +: 2] = st_q.ax[i].mode;
                    end
                    st_d.rdata[AESD_ST_ALARM_BIT] = st_q.enAlarm;
                    st_d.rdata[AESD_ST_ABORT_BIT] = st_q.abort;
                end
                default:          st_d.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q         <= '0;
            st_q.brake   <= AESD_RST_BRAKE;
            st_q.delay   <= AESD_RST_DELAY;
            st_q.still   <= AESD_RST_STILL;
            st_q.lube    <= AESD_RST_LUBE;
            st_q.rampTol <= AESD_RST_RAMPTOL;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < AESD_AXES; i++) begin
            axOut[i] = st_q.ax[i].out;
        end
    end
    assign brakeRampTime   = st_q.brake;
    assign drivesCyclic    = st_q.cyclic;
    assign groupDriveReady = st_q.grpReady;
    assign kernelAlarm     = st_q.kAlarm;
    assign tempAlarm       = st_q.tAlarm;
    assign chanAlarm       = st_q.cAlarm;
    assign chanStopAlarm   = st_q.cStop;
    assign foreignLang     = st_q.foreign;
    assign programAbort    = st_q.abort;
    assign alarmCode       = st_q.enAlarm ? AESD_ALARM_ENLOST : 16'h0000;
    assign regRdata        = st_q.rdata;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    for (genvar i = 0; i < AESD_AXES; i++) begin : g_chk
        a_estop_opens_loop: assert property (
            @(posedge mclk) disable iff (rst)
            estopActive |=> !axOut[i].posCtrlActive)
            else $error("position loop closed after emergency stop");
        a_pos_needs_enable: assert property (
            @(posedge mclk) disable iff (rst)
            axOut[i].posCtrlActive |-> $past(axIn[i].enableReq))
            else $error("position loop closed without enable request");
        a_pulse_needs_all: assert property (
            @(posedge mclk) disable iff (rst)
            axOut[i].pulsesEnabled |-> $past(axIn[i].pulseEnReq && axIn[i].driveOk)
                                       && axOut[i].spdCtrlActive)
            else $error("pulses enabled without all enables");
        a_zero_set_drive_off: assert property (
            @(posedge mclk) disable iff (rst)
            $rose(axOut[i].zeroSetpoint) |-> !axOut[i].spdCtrlActive
                                             && $past(axOut[i].brakeActive))
            else $error("zero setpoint without drive removal");
        a_lock_holds_off: assert property (
            @(posedge mclk) disable iff (rst)
            axOut[i].zeroSetpoint && !ctrlReset |=> axOut[i].zeroSetpoint
                                                    && !axOut[i].posCtrlActive)
            else $error("locked axis left disabled state without reset");
        a_ramp_done_sticky: assert property (
            @(posedge mclk) disable iff (rst)
            axOut[i].rampUpDone && $stable(axIn[i].setSpeed) |=> axOut[i].rampUpDone)
            else $error("ramp-up done cleared without new setpoint");
        a_integ_follows: assert property (
            @(posedge mclk) disable iff (rst)
            axIn[i].intInhibitReq ##1 axIn[i].intInhibitReq |=> axOut[i].integratorOff[*1])
            else $error("integrator inhibit not reported");
        a_brake_bounded: assert property (
            @(posedge mclk) disable iff (rst)
            $rose(axOut[i].brakeActive) && st_q.delay < 24'h000384
            |-> ##[1:1000] !axOut[i].brakeActive)
            else $error("drive enable not removed after shutdown delay");
    end

    a_group_ready: assert property (
        @(posedge mclk) disable iff (rst)
        groupDriveReady |-> $past(allReady))
        else $error("group drive ready with a drive not ready");
    a_alarm_to_kernel: assert property (
        @(posedge mclk) disable iff (rst)
        (alarmCode != 16'h0000) |-> kernelAlarm && chanAlarm)
        else $error("pending alarm not reported");
    a_trip_aborts: assert property (
        @(posedge mclk) disable iff (rst)
        groupTrip && !ctrlReset |=> programAbort && chanStopAlarm)
        else $error("group stop did not abort program");

    c_estop_brake: cover property (
        @(posedge mclk) disable iff (rst) estopActive ##1 axOut[0].brakeActive);
    c_timeout_lock: cover property (
        @(posedge mclk) disable iff (rst) $rose(axOut[0].zeroSetpoint));
    c_group_abort: cover property (
        @(posedge mclk) disable iff (rst) $rose(programAbort));
    c_lube_toggle: cover property (
        @(posedge mclk) disable iff (rst) $changed(axOut[1].lubePulse));

endmodule : aesd_core

`default_nettype wire

//--- testbench/aesd_plc_model.sv
// PLC user program model: per-axis request bits and drive feedback.
// Assumes the bench gives the enable mask and one common speed.
`timescale 1ns/1ps
`default_nettype none
module aesd_plc_model
    import aesd_pkg::*;
(
    input  wire logic [3:0]                enMask,
    input  wire logic [15:0]               speed,
    output var aesd_axin_s [AESD_AXES-1:0] axIn
);
    // Healthy drives; odd axes inhibit the integrator
    always_comb begin
        for (int i = 0; i < AESD_AXES; i++) begin
            axIn[i] = '0;
            axIn[i].enableReq = enMask[i];
            axIn[i].intInhibitReq = i[0];
            axIn[i].pulseEnReq = 1'b1;
            axIn[i].groupMember = (i < 2);  // Axes 0 and 1 share one group
            axIn[i].driveRamped = 1'b1;
            axIn[i].travel = speed;
            axIn[i].driveAvail = 1'b1;
            axIn[i].driveOk = 1'b1;
            axIn[i].actSpeed = speed;
            axIn[i].setSpeed = speed;
        end
    end
endmodule : aesd_plc_model
`default_nettype wire

//--- testbench/axis_enable_shutdown_status_bench.sv
// Bench: e-stop shutdown, lock until reset, loop and status bits.
// Assumes the PLC model file and the design package.
`timescale 1ns/1ps
`default_nettype none
module axis_enable_shutdown_status_bench;
    import aesd_pkg::*;
    logic                        mclk, rst, ctrlRst, estop, tFault, regWr, regRd;
    logic                        tempAlarm, kernelAlarm, cyc, grpRdy, chAl, chStop, frgn, abrt;
    logic [4:0]                  extIn;
    logic [3:0]                  enMask;
    logic [7:0]                  regAddr;
    logic [15:0]                 speed, alarmCode, brk;
    logic [31:0]                 regWdata, regRdata, d;
    aesd_axin_s [AESD_AXES-1:0]  axIn;
    aesd_axout_s [AESD_AXES-1:0] axOut;
    int seed = 32'h61317a68, miscompares, samplesChecked, spd;
    aesd_plc_model plc (.enMask(enMask), .speed(speed), .axIn(axIn));
    aesd_core DUT (.mclk(mclk), .rst(rst), .ctrlReset(ctrlRst), .estopActive(estop),
        .tempFault(tFault), .kernelAlarmIn(extIn[0]), .chanAlarmIn(extIn[1]),
        .chanStopAlarmIn(extIn[2]), .foreignLangDone(extIn[3]), .nativeLangDone(extIn[4]),
        .axIn(axIn), .axOut(axOut), .brakeRampTime(brk), .drivesCyclic(cyc),
        .groupDriveReady(grpRdy), .kernelAlarm(kernelAlarm), .tempAlarm(tempAlarm),
        .chanAlarm(chAl), .chanStopAlarm(chStop), .foreignLang(frgn),
        .programAbort(abrt), .alarmCode(alarmCode), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    // Clock, 25 ns period
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samplesChecked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk) {regWr, regAddr, regWdata} <= {1'b1, a, v};
        @(posedge mclk) regWr <= 1'b0;
    endtask : wr
    // Read data is only valid the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge mclk) {regRd, regAddr} <= {1'b1, a};
        @(posedge mclk) regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task printVerdict;
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : printVerdict
    // Watchdog well beyond the expected run
    initial begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        printVerdict;
    end
    initial begin
        {rst, ctrlRst, estop, tFault, regWr, regRd, enMask, speed} = 26'h2000000;
        {regAddr, regWdata, extIn} = '0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(AESD_REG_DELAY);
        chk("delayRst", {8'h00, AESD_RST_DELAY}, d);
        rd(8'h40);
        chk("unmapped", 32'h0, d);
        wr(AESD_REG_DELAY, 32'h14);
        wr(AESD_REG_LUBE, 32'h50);
        enMask <= 4'hf;
        tFault <= 1'b1;
        tick(3);
        for (int i = 0; i < AESD_AXES; i++) begin
            chk("posCtl", 1, axOut[i].posCtrlActive);
            chk("integOff", i % 2, axOut[i].integratorOff);
            chk("pulses", 1, axOut[i].pulsesEnabled);
            chk("curCtl", 1, axOut[i].curCtrlActive);
        end
        chk("temp", 1, tempAlarm);
        chk("cyclic", 1, cyc);
        chk("grpReady", 1, grpRdy);
        chk("brakeTime", AESD_RST_BRAKE, brk);
        spd = 100 + $unsigned($random(seed)) % 900;
        speed <= 16'(spd);
        tick(3);
        chk("still", spd <= 4, axOut[0].stationary);
        chk("ramp", 1, axOut[0].rampUpDone);
        d[0] = axOut[1].lubePulse;
        tick(1);
        chk("lube", !d[0], axOut[1].lubePulse);
        estop <= 1'b1;
        tick(2);
        chk("posOff", 0, axOut[0].posCtrlActive);
        chk("brake", 1, axOut[0].brakeActive);
        tick(27);
        chk("zeroSet", 1, axOut[0].zeroSetpoint);
        chk("spdOff", 0, axOut[0].spdCtrlActive);
        chk("alarm", 32'h546c, alarmCode);
        chk("kAlarm", 1, kernelAlarm);
        chk("abort", 1, abrt);
        chk("stopBit", 1, chStop);
        d = axOut[0].actualPos;
        tick(1);
        chk("pos", d + spd, axOut[0].actualPos);
        {estop, speed} <= '0;
        tick(4);
        chk("locked", 0, axOut[0].posCtrlActive);
        ctrlRst <= 1'b1;
        tick(1);
        ctrlRst <= 1'b0;
        tick(4);
        chk("rearmed", 1, axOut[0].posCtrlActive);
        chk("alarmClr", 0, alarmCode);
        chk("abortClr", 0, abrt);
        extIn <= 5'b01011;
        tick(2);
        chk("kIn", 1, kernelAlarm);
        chk("chAlarm", 1, chAl);
        chk("foreign", 1, frgn);
        extIn <= 5'b10100;
        tick(2);
        chk("chStopIn", 1, chStop);
        chk("native", 0, frgn);
        chk("chClr", 0, chAl);
        printVerdict;
    end
endmodule : axis_enable_shutdown_status_bench
`default_nettype wire
